// ---- verilog/power_down_pkg.sv ----
// constants, register layout and state encoding for the power-down mode controller
package power_down_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W                = 32;
    localparam int unsigned DATA_W                = 32;
    localparam int unsigned BE_W                  = 4;
    localparam int unsigned REG_W                 = 8;
    localparam logic [31:0] STANDBY_CONTROL_INDEX = 32'hFFFFFF82;
    localparam logic [7:0]  STANDBY_CONTROL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // standby_control fields
    // ------------------------------------------------------------------
    localparam int unsigned STANDBY_SELECT_BIT    = 7;
    localparam int unsigned MSTOP_TIMER_BIT       = 2;
    localparam int unsigned MSTOP_CALENDAR_BIT    = 1;
    localparam int unsigned MSTOP_SERIAL_BIT      = 0;
    localparam logic [7:0]  STANDBY_CONTROL_MASK  = 8'h87;

    // ------------------------------------------------------------------
    // settling counter
    // ------------------------------------------------------------------
    localparam int unsigned SETTLE_W              = 16;
    localparam logic [15:0] SETTLE_ONE            = 16'h0001;

    // ------------------------------------------------------------------
    // operating states, gray along run -> sleep -> standby -> settle
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN        = 3'h0,
        ST_SLEEP      = 3'h1,
        ST_STANDBY    = 3'h3,
        ST_SETTLE     = 3'h2,
        ST_HW_STANDBY = 3'h6
    } pd_state_e;

endpackage

// ---- verilog/pin_sync.sv ----
// two-flop synchroniser for one asynchronous pin
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      pin_sync_out
);

    logic stage1;

    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1       <= RESET_LEVEL;
            pin_sync_out <= RESET_LEVEL;
        end else begin
            stage1       <= pin_in;
            pin_sync_out <= stage1;
        end
    end

endmodule // pin_sync

// ---- verilog/power_down_mode_control.sv ----
// power-down mode controller: sleep, standby, hardware standby, module stop, status pins
//
// Contract
// - sleep instruction with standby_select 0 halts the cpu only, clocks, peripherals and refresh go on.
// - sleep instruction with standby_select 1 halts clock_gen, cpu and peripherals and asks for self-refresh.
// - hw_standby_pin driven low enters hardware standby, halting clock_gen and cpu, and the timer except while manual_reset is held, until power-on reset.
// - a module_stop bit at 1 gates the clock of its peripheral, except the calendar's in either standby; clearing it or any reset restores the clock.
// - while stopped the timer pins keep their state and the serial pins return to their reset state.
// - in standby the calendar keeps running if started, the timer only when fed from the calendar.
// - standby_control clears on power-on reset and keeps its value through a manual reset.
// - standby_control is a byte read/write register at H'FFFFFF82.
// - status pins show hi/hi reset, hi/lo sleep, lo/hi standby, lo/lo normal.
// - during refresh cycles the status pins show normal operation even in sleep.
// - sleep ends on nmi, external-level or peripheral interrupt or any reset; interrupts start exception handling.
// - a standby exit interrupt waits the watchdog settling time before clocks are restored.
`timescale 1ns/1ps
module power_down_mode_control
    import power_down_pkg::*;
(
    input  wire logic                                mclk,
    input  wire logic                                rst,
    input  wire logic                                manual_reset,
    // avalon-mm slave
    input  wire logic [power_down_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [power_down_pkg::DATA_W-1:0]   avs_writedata,
    input  wire logic [power_down_pkg::BE_W-1:0]     avs_byteenable,
    output logic      [power_down_pkg::DATA_W-1:0]   avs_readdata,
    output logic                                     avs_waitrequest,
    // cpu and interrupt side
    input  wire logic                                sleep_exec,
    input  wire logic                                nmi_req,
    input  wire logic                                irl_req,
    input  wire logic                                periph_irq,
    input  wire logic                                refresh_cycle,
    input  wire logic [power_down_pkg::SETTLE_W-1:0] settle_cycles,
    input  wire logic                                calendar_start,
    input  wire logic                                timer_src_calendar,
    // pin from the outside party, active low
    input  wire logic                                hw_standby_pin_n,
    // controls to the rest of the chip
    output logic                                     cpu_halt,
    output logic                                     clock_gen_stop,
    output logic                                     periph_stop,
    output logic                                     self_refresh_req,
    output logic                                     exception_start,
    output logic                                     timer_clk_en,
    output logic                                     calendar_clk_en,
    output logic                                     serial_clk_en,
    output logic                                     timer_pin_hold,
    output logic                                     serial_pin_reset,
    // processing-status pins
    output logic                                     proc_state_hi,
    output logic                                     proc_state_lo
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [REG_W-1:0]    standby_control;
    logic                bus_ack;
    logic                reg_hit;
    logic                hw_standby_sync_n;
    pd_state_e           state;
    pd_state_e           next_state;
    logic [SETTLE_W-1:0] settle_count;
    logic                wake_irq;
    logic                state_hi;
    logic                state_lo;
    logic                any_reset;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic mstop(input logic [REG_W-1:0] ctrl, input int unsigned bit_pos);
        mstop = ctrl[bit_pos];
    endfunction

    // standby, settle and hardware standby all run with clock_gen halted
    function automatic logic clocks_stopped(input pd_state_e s);
        clocks_stopped = (s == ST_STANDBY) || (s == ST_SETTLE) || (s == ST_HW_STANDBY);
    endfunction

    // a programmed count of 0 or 1 both give a single settle cycle
    function automatic logic settle_done(input logic [SETTLE_W-1:0] count);
        settle_done = (count <= SETTLE_ONE);
    endfunction

    assign any_reset = rst | manual_reset;
    assign wake_irq  = nmi_req | irl_req | periph_irq;

    // ------------------------------------------------------------------
    // hardware standby pin synchroniser
    // ------------------------------------------------------------------
    pin_sync #(
        .RESET_LEVEL (1'b1)
    ) u_hw_standby_sync (
        .mclk         (mclk),
        .rst          (rst),
        .pin_in       (hw_standby_pin_n),
        .pin_sync_out (hw_standby_sync_n)
    );

    // ------------------------------------------------------------------
    // avalon-mm slave: one wait cycle, then answer
    // ------------------------------------------------------------------
    assign reg_hit         = (avs_address == STANDBY_CONTROL_INDEX);
    assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;

    // ack lasts one cycle, so a request held through its answer is taken only once
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= (avs_read | avs_write) & ~bus_ack;
        end
    end

    // read data is loaded at the taking edge and stands until the next read
    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (avs_read & ~bus_ack) begin
            avs_readdata <= reg_hit ? {{(DATA_W-REG_W){1'b0}}, standby_control} : '0;
        end
    end

    // ------------------------------------------------------------------
    // standby_control register
    // ------------------------------------------------------------------
    // only the power-on reset clears it; a manual reset keeps mode and module stops
    always_ff @(posedge mclk) begin
        if (rst) begin
            standby_control <= STANDBY_CONTROL_RESET;
        end else if (avs_write & ~bus_ack & reg_hit & avs_byteenable[0]) begin
            standby_control <= avs_writedata[REG_W-1:0] & STANDBY_CONTROL_MASK;
        end
    end

    // ------------------------------------------------------------------
    // mode state machine
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RUN: begin
                if (sleep_exec) begin
                    next_state = standby_control[STANDBY_SELECT_BIT] ? ST_STANDBY : ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_irq) begin
                    next_state = ST_RUN;
                end
            end
            ST_STANDBY: begin
                if (wake_irq) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (settle_done(settle_count)) begin
                    next_state = ST_RUN;
                end
            end
            ST_HW_STANDBY: begin
                next_state = ST_HW_STANDBY;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
        if (manual_reset && state != ST_HW_STANDBY) begin
            next_state = ST_RUN;
        end
        // hardware standby outranks every other request and only rst leaves it
        if (!hw_standby_sync_n) begin
            next_state = ST_HW_STANDBY;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // settling counter
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            settle_count <= '0;
        end else if (state == ST_STANDBY && wake_irq) begin
            settle_count <= settle_cycles;
        end else if (state == ST_SETTLE && settle_count != '0) begin
            settle_count <= settle_count - SETTLE_ONE;
        end
    end

    // ------------------------------------------------------------------
    // exception entry
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            exception_start <= 1'b0;
        end else begin
            exception_start <= ~manual_reset & hw_standby_sync_n &
                               ((state == ST_SLEEP && wake_irq) ||
                                (state == ST_SETTLE && settle_done(settle_count)));
        end
    end

    // ------------------------------------------------------------------
    // cpu and clock halts
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            cpu_halt <= 1'b0;
        end else begin
            cpu_halt <= (next_state != ST_RUN);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            clock_gen_stop <= 1'b0;
        end else begin
            clock_gen_stop <= clocks_stopped(next_state);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            periph_stop <= 1'b0;
        end else begin
            periph_stop <= clocks_stopped(next_state);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            self_refresh_req <= 1'b0;
        end else begin
            self_refresh_req <= clocks_stopped(next_state);
        end
    end

    // ------------------------------------------------------------------
    // module clock enables
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_clk_en    <= 1'b1;
            calendar_clk_en <= 1'b1;
            serial_clk_en   <= 1'b1;
        end else if (manual_reset) begin
            timer_clk_en    <= 1'b1;
            calendar_clk_en <= 1'b1;
            serial_clk_en   <= 1'b1;
        end else begin
            unique case (next_state)
                ST_STANDBY, ST_SETTLE: begin
                    calendar_clk_en <= calendar_start;
                    timer_clk_en    <= calendar_start & timer_src_calendar &
                                       ~mstop(standby_control, MSTOP_TIMER_BIT);
                    serial_clk_en   <= 1'b0;
                end
                ST_HW_STANDBY: begin
                    calendar_clk_en <= calendar_start;
                    timer_clk_en    <= 1'b0;
                    serial_clk_en   <= 1'b0;
                end
                default: begin
                    timer_clk_en    <= ~mstop(standby_control, MSTOP_TIMER_BIT);
                    calendar_clk_en <= ~mstop(standby_control, MSTOP_CALENDAR_BIT);
                    serial_clk_en   <= ~mstop(standby_control, MSTOP_SERIAL_BIT);
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // module pin controls
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_pin_hold <= 1'b0;
        end else begin
            timer_pin_hold <= ~manual_reset & mstop(standby_control, MSTOP_TIMER_BIT);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            serial_pin_reset <= 1'b0;
        end else begin
            serial_pin_reset <= ~manual_reset & mstop(standby_control, MSTOP_SERIAL_BIT);
        end
    end

    // ------------------------------------------------------------------
    // processing-status pins
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_hi <= 1'b1;
            state_lo <= 1'b1;
        end else if (manual_reset) begin
            state_hi <= 1'b1;
            state_lo <= 1'b1;
        end else if (refresh_cycle) begin
            state_hi <= 1'b0;
            state_lo <= 1'b0;
        end else begin
            unique case (next_state)
                ST_SLEEP: begin
                    state_hi <= 1'b1;
                    state_lo <= 1'b0;
                end
                ST_STANDBY, ST_SETTLE, ST_HW_STANDBY: begin
                    state_hi <= 1'b0;
                    state_lo <= 1'b1;
                end
                default: begin
                    state_hi <= 1'b0;
                    state_lo <= 1'b0;
                end
            endcase
        end
    end

    // reset encoding shows immediately while either reset is held
    assign proc_state_hi = state_hi | any_reset;
    assign proc_state_lo = state_lo | any_reset;

endmodule // power_down_mode_control

// ---- bench/power_down_assertions.sv ----
// concurrent checks on the power-down controller ports
`timescale 1ns/1ps
module power_down_checker (
    input logic mclk,
    input logic rst,
    input logic manual_reset,
    input logic avs_read,
    input logic avs_write,
    input logic avs_waitrequest,
    input logic sleep_exec,
    input logic nmi_req,
    input logic irl_req,
    input logic periph_irq,
    input logic refresh_cycle,
    input logic hw_standby_pin_n,
    input logic cpu_halt,
    input logic clock_gen_stop,
    input logic periph_stop,
    input logic self_refresh_req,
    input logic exception_start,
    input logic timer_clk_en,
    input logic proc_state_hi,
    input logic proc_state_lo
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst || manual_reset);

    a_status_reset: assert property (disable iff (1'b0)
        (rst || manual_reset) |-> proc_state_hi && proc_state_lo)
        else $error("status not reset encoding");
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered");
    a_sleep_entry: assert property (sleep_exec && !cpu_halt && hw_standby_pin_n |-> ##[1:2] cpu_halt)
        else $error("sleep instruction did not halt cpu");
    a_refresh_normal: assert property ($past(refresh_cycle) && hw_standby_pin_n
        |-> !proc_state_hi && !proc_state_lo)
        else $error("refresh not shown as normal");
    a_sleep_pins: assert property (cpu_halt && !clock_gen_stop && !periph_stop && !self_refresh_req
        && !$past(refresh_cycle) |-> proc_state_hi && !proc_state_lo)
        else $error("sleep encoding wrong");
    a_standby_pins: assert property (clock_gen_stop && hw_standby_pin_n |-> !proc_state_hi && proc_state_lo)
        else $error("standby encoding wrong");
    a_standby_halts: assert property (clock_gen_stop |-> cpu_halt && periph_stop)
        else $error("standby left cpu or peripherals running");
    a_sleep_wake: assert property (cpu_halt && !clock_gen_stop && !periph_stop
        && (nmi_req || irl_req || periph_irq) |-> ##[1:3] (exception_start && !cpu_halt))
        else $error("sleep not left on interrupt");
    a_hw_entry: assert property ($fell(hw_standby_pin_n)
        |-> ##[1:6] (clock_gen_stop && cpu_halt && !timer_clk_en))
        else $error("hardware standby not entered");

    c_sleep: cover property (cpu_halt && proc_state_hi && !proc_state_lo);
    c_standby: cover property (clock_gen_stop && hw_standby_pin_n);
    c_hw_standby: cover property (clock_gen_stop && !hw_standby_pin_n);
endmodule // power_down_checker

bind power_down_mode_control power_down_checker power_down_checker_inst (.mclk, .rst, .manual_reset, .avs_read,
    .avs_write, .avs_waitrequest, .sleep_exec, .nmi_req, .irl_req, .periph_irq, .refresh_cycle, .hw_standby_pin_n,
    .cpu_halt, .clock_gen_stop, .periph_stop, .self_refresh_req, .exception_start, .timer_clk_en, .proc_state_hi,
    .proc_state_lo);

// ---- bench/standby_pin_partner.sv ----
// outside party: drives the hardware-standby pin and watches the status pins
`timescale 1ns/1ps
module standby_pin_partner (
    input  logic       mclk,
    input  logic       rst,
    input  logic       enter,
    input  logic       proc_state_hi,
    input  logic       proc_state_lo,
    output logic       hw_standby_pin_n,
    output logic [1:0] state_seen
);
    // pin stays low until power-on reset, the only way out
    always_ff @(posedge mclk) begin
        if (rst) begin
            hw_standby_pin_n <= 1'b1;
        end else if (enter) begin
            hw_standby_pin_n <= 1'b0;
        end
    end
    always_ff @(posedge mclk) begin
        state_seen <= {proc_state_hi, proc_state_lo};
    end
endmodule // standby_pin_partner

// ---- bench/power_down_mode_control_test.sv ----
// self-checking testbench for the power-down mode controller
`timescale 1ns/1ps
module power_down_mode_control_test;
    import power_down_pkg::*;
    logic mclk = '0, rst = 1'b1, manual_reset = '0, avs_read = '0, avs_write = '0, sleep_exec = '0;
    logic nmi_req = '0, irl_req = '0, periph_irq = '0, refresh_cycle = '0, calendar_start = '0;
    logic timer_src_calendar = '0, hw_go = '0;
    logic [31:0] avs_address = '0, avs_writedata = '0, avs_readdata, rd;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [15:0] settle_cycles = 16'h0008;
    logic avs_waitrequest, hw_standby_pin_n, cpu_halt, clock_gen_stop, periph_stop, self_refresh_req;
    logic exception_start, timer_clk_en, calendar_clk_en, serial_clk_en, timer_pin_hold, serial_pin_reset;
    logic proc_state_hi, proc_state_lo;
    logic [1:0] pin_seen;
    int   n_errors = 0, comparisons = 0;

    power_down_mode_control power_down_mode_control_inst (.mclk, .rst, .manual_reset, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sleep_exec, .nmi_req,
        .irl_req, .periph_irq, .refresh_cycle, .settle_cycles, .calendar_start, .timer_src_calendar,
        .hw_standby_pin_n, .cpu_halt, .clock_gen_stop, .periph_stop, .self_refresh_req, .exception_start,
        .timer_clk_en, .calendar_clk_en, .serial_clk_en, .timer_pin_hold, .serial_pin_reset, .proc_state_hi,
        .proc_state_lo);
    standby_pin_partner standby_pin_partner_inst (.mclk, .rst, .enter(hw_go), .proc_state_hi, .proc_state_lo,
        .hw_standby_pin_n, .state_seen(pin_seen));

    always #5 mclk = ~mclk;

    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic wr, input logic [31:0] d, input logic [31:0] a = STANDBY_CONTROL_INDEX,
             input logic [3:0] be = 4'hF);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task sleep_now;
        @(posedge mclk);
        sleep_exec <= 1'b1;
        @(posedge mclk);
        sleep_exec <= 1'b0;
    endtask
    task wake(input int src);
        @(posedge mclk);
        nmi_req <= (src == 0);
        irl_req <= (src == 1);
        periph_irq <= (src == 2);
        @(posedge mclk);
        {nmi_req, irl_req, periph_irq} <= 3'h0;
    endtask

    task t_reg;
        bus(0, 32'h0);
        chk(rd, 32'h0, "reset value");
        bus(1, 32'hFFFFFF87);
        bus(0, 32'h0);
        chk(rd, 32'h00000087, "upper bytes dropped");
        bus(1, 32'h0, STANDBY_CONTROL_INDEX, 4'hE);
        bus(0, 32'h0);
        chk(rd, 32'h00000087, "byte lane off");
        bus(0, 32'h0, 32'hFFFFFF83);
        chk(rd, 32'h0, "unmapped read");
        @(posedge mclk);
        manual_reset <= 1'b1;
        tick(3);
        chk({proc_state_hi, proc_state_lo}, 2'h3, "manual reset status");
        chk({timer_clk_en, calendar_clk_en, serial_clk_en}, 3'h7, "clocks on in reset");
        manual_reset <= 1'b0;
        bus(0, 32'h0);
        chk(rd, 32'h00000087, "kept by manual reset");
        bus(1, 32'h0);
        $display("register test done");
    endtask
    task t_mstop;
        bus(1, 32'h00000007);
        tick(3);
        chk({timer_clk_en, calendar_clk_en, serial_clk_en, cpu_halt}, 4'h0, "module stop");
        chk({timer_pin_hold, serial_pin_reset}, 2'h3, "stopped pins");
        bus(1, 32'h0);
        tick(3);
        chk({timer_clk_en, calendar_clk_en, serial_clk_en}, 3'h7, "module restart");
        $display("module stop test done");
    endtask
    task t_sleep(input int src);
        sleep_now();
        tick(2);
        chk({proc_state_hi, proc_state_lo}, 2'h2, "sleep status");
        chk({cpu_halt, clock_gen_stop, periph_stop, self_refresh_req}, 4'h8, "sleep halts");
        @(posedge mclk);
        refresh_cycle <= 1'b1;
        @(posedge mclk);
        refresh_cycle <= 1'b0;
        @(posedge mclk);
        chk({proc_state_hi, proc_state_lo}, 2'h0, "refresh status");
        tick(1);
        chk({proc_state_hi, proc_state_lo}, 2'h2, "after refresh");
        wake(src);
        tick(3);
        chk({cpu_halt, proc_state_hi, proc_state_lo}, 3'h0, "sleep wake");
        $display("sleep test done");
    endtask
    task t_standby;
        calendar_start <= 1'b1;
        bus(1, 32'h00000080);
        sleep_now();
        tick(3);
        chk({proc_state_hi, proc_state_lo}, 2'h1, "standby status");
        chk({cpu_halt, clock_gen_stop, periph_stop, self_refresh_req}, 4'hF, "standby halts");
        chk({timer_clk_en, calendar_clk_en}, 2'h1, "calendar runs");
        timer_src_calendar <= 1'b1;
        tick(2);
        chk(timer_clk_en, 1'b1, "timer on calendar");
        wake(1);
        tick(3);
        chk(cpu_halt, 1'b1, "settling");
        tick(12);
        chk({cpu_halt, clock_gen_stop, proc_state_hi, proc_state_lo}, 4'h0, "standby wake");
        calendar_start <= 1'b0;
        timer_src_calendar <= 1'b0;
        $display("standby test done");
    endtask
    task t_hw;
        bus(1, 32'h00000081);
        hw_go <= 1'b1;
        tick(8);
        chk({cpu_halt, clock_gen_stop, timer_clk_en}, 3'h6, "hw standby");
        chk(pin_seen, 2'h1, "partner sees standby");
        wake(0);
        tick(4);
        chk(clock_gen_stop, 1'b1, "interrupt ignored");
        rst <= 1'b1;
        hw_go <= 1'b0;
        tick(4);
        chk({proc_state_hi, proc_state_lo}, 2'h3, "reset status");
        rst <= 1'b0;
        tick(3);
        chk({cpu_halt, clock_gen_stop, proc_state_hi, proc_state_lo}, 4'h0, "hw standby left");
        bus(0, 32'h0);
        chk(rd, 32'h0, "power-on clear");
        $display("hardware standby test done");
    endtask

    task wrap_up;
        $display("%0d comparisons, %0d errors", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_reg();
        t_mstop();
        for (int s = 0; s < 3; s++) t_sleep(s);
        t_standby();
        t_hw();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        wrap_up();
    end
endmodule // power_down_mode_control_test
